// ==== design/ahc_alarm_history.sv ====
`timescale 1ns/1ps
`include "ahc_cfg.svh"
// What this block does
// - Out-of-range travel raises sub code 01h.
// - Wrap operation while wrap disabled: 02h.
// - Nonzero travel at zero speed: 03h.
// - Operating speed above sensor maximum: 04h.
// - Starting speed above sensor maximum: 05h.
// - Push speed above sensor ceiling: 06h.
// - Push current above sensor ceiling: 07h.
// - Home setting above sensor limit: 08h.
// - Motor supply type mismatch: combination alarm.
// - Actuator on firmware before 2.02: combination.
// - DC small frame at 48V, firmware>=3.10.
// - Actuator with fractional lead on firmware before 4.10.
// - Record code, sub, temperatures, inverter voltage.
// - Record direct inputs and remote outputs.
// - Record data number, operation kind, position.
// - Record boot, motion and main times.
// - No control supply: boot from main.
// - Remote outputs sampled even without network.
module ahc_alarm_history
  import ahc_pkg::*;
#(
  parameter int DEPTH    = 8,
  parameter int TICK_CYC = `AHC_TICK_CYC
) (
  // Clock and reset
  input  wire logic                     clock_in,
  input  wire logic                     arst_n_in,
  // Driver configuration
  input  wire logic                     drv_dc_in,
  input  wire logic [15:0]              fw_rev_in,
  input  wire logic                     supply_48v_in,
  input  wire logic                     wrap_en_in,
  input  wire logic                     follow_sensor_in,
  // Motor and sensor
  input  wire logic                     motor_valid_in,
  input  wire ahc_motor_s               motor_in,
  input  wire ahc_lim_s                 lim_in,
  // Operation start
  input  wire logic                     op_start_in,
  input  wire ahc_op_s                  op_in,
  // Other alarm sources
  input  wire logic                     ext_alarm_in,
  input  wire logic [7:0]               ext_code_in,
  input  wire logic [7:0]               ext_sub_in,
  // Live snapshot
  input  wire ahc_snap_s                snap_in,
  input  wire logic                     ctrl_pwr_present_in,
  input  wire logic                     ctrl_pwr_on_in,
  input  wire logic                     main_pwr_on_in,
  // Alarm status
  output logic                          combo_alarm_out,
  output logic                          opdata_alarm_out,
  output logic [7:0]                    opdata_sub_out,
  // History read
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx_in,
  output ahc_rec_s                      rd_rec_out,
  output logic [$clog2(DEPTH):0]        count_out
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic over(input logic [31:0] val, input logic [31:0] lim);
    over = val > lim;
  endfunction : over

  logic        [32:0] tv;
  logic               tr_bad;
  logic        [7:0]  sub_sel;
  logic               op_err;
  logic               combo_now;
  logic               combo_rise;
  logic               ev;
  logic        [7:0]  ev_code;
  logic        [7:0]  ev_sub;
  logic        [31:0] t_boot;
  logic        [31:0] t_move;
  logic        [31:0] t_main;
  logic        [15:0] rio_q;
  ahc_rec_s           mem_q [DEPTH];
  logic        [AW-1:0] wp_q;
  logic        [AW:0]   cnt_q;
  logic        [AW-1:0] old_idx;

  assign tv     = op_in.travel;
  assign tr_bad = ($signed(tv) > `AHC_TRAVEL_MAX) || ($signed(tv) < -`AHC_TRAVEL_MAX);

  // Lowest sub code wins when several causes hold
  assign sub_sel =
      (op_in.positioning && tr_bad)                         ? `AHC_SUB_TRAVEL :
      (op_in.uses_wrap && !wrap_en_in)                      ? `AHC_SUB_WRAP :
      (op_in.positioning && tv != 33'h0_0000_0000 &&
       op_in.op_speed == 32'h0000_0000)                     ? `AHC_SUB_SPEED0 :
      (follow_sensor_in &&
       over(op_in.op_speed, lim_in.max_op_speed))           ? `AHC_SUB_OPSPD :
      (follow_sensor_in &&
       over(op_in.st_speed, lim_in.max_st_speed))           ? `AHC_SUB_STSPD :
      (follow_sensor_in && op_in.push &&
       over(op_in.push_speed, lim_in.max_push_speed))       ? `AHC_SUB_PUSHSPD :
      (follow_sensor_in && op_in.push &&
       op_in.push_cur > lim_in.max_push_cur)                ? `AHC_SUB_PUSHCUR :
      (follow_sensor_in && op_in.home &&
       over(op_in.home_speed, lim_in.max_home_speed))       ? `AHC_SUB_HOME :
                                                              `AHC_SUB_NONE;
  assign op_err = op_start_in && (sub_sel != `AHC_SUB_NONE);

  assign combo_now = motor_valid_in && (
      (motor_in.motor_dc != drv_dc_in) ||
      (motor_in.actuator && fw_rev_in < `AHC_FW_ACTUATOR) ||
      (drv_dc_in && fw_rev_in >= `AHC_FW_HV_CHECK &&
       motor_in.small_frame && supply_48v_in) ||
      (motor_in.actuator && motor_in.frac_lead &&
       fw_rev_in < `AHC_FW_FRAC_LEAD));
  assign combo_rise = combo_now && !combo_alarm_out;

  // Combination alarm takes the record slot when both arise together
  assign ev      = combo_rise || op_err || ext_alarm_in;
  assign ev_code = combo_rise ? `AHC_ALM_COMBO : op_err ? `AHC_ALM_OPDATA : ext_code_in;
  assign ev_sub  = combo_rise ? `AHC_SUB_NONE  : op_err ? sub_sel : ext_sub_in;

  assign old_idx = (cnt_q == (AW+1)'(DEPTH)) ? wp_q : AW'(0);

  ahc_timers #(
    .TICK_CYC            (TICK_CYC)
  ) u_timers (
    .clock_in            (clock_in),
    .arst_n_in           (arst_n_in),
    .ctrl_pwr_present_in (ctrl_pwr_present_in),
    .ctrl_pwr_on_in      (ctrl_pwr_on_in),
    .main_pwr_on_in      (main_pwr_on_in),
    .motion_start_in     (op_start_in),
    .t_boot_out          (t_boot),
    .t_move_out          (t_move),
    .t_main_out          (t_main)
  );

  // Remote outputs are sampled regardless of network use
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) rio_q <= 16'h0000;
    else            rio_q <= snap_in.rio_out;
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      combo_alarm_out  <= 1'b0;
      opdata_alarm_out <= 1'b0;
      opdata_sub_out   <= 8'h00;
    end else begin
      combo_alarm_out <= combo_now;
      if (op_err) begin
        opdata_alarm_out <= 1'b1;
        opdata_sub_out   <= sub_sel;
      end else if (op_start_in) begin
        opdata_alarm_out <= 1'b0;
        opdata_sub_out   <= 8'h00;
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wp_q  <= '0;
      cnt_q <= '0;
    end else if (ev) begin
      wp_q  <= (wp_q == AW'(DEPTH - 1)) ? AW'(0) : wp_q + AW'(1);
      if (cnt_q != (AW+1)'(DEPTH)) cnt_q <= cnt_q + (AW+1)'(1);
    end
  end

  // A motion that starts in the event cycle has no elapsed move time yet
  always_ff @(posedge clock_in) begin
    if (ev) begin
      mem_q[wp_q] <= '{code: ev_code, sub: ev_sub,
                       drv_temp: snap_in.drv_temp, mot_temp: snap_in.mot_temp,
                       inv_volt: snap_in.inv_volt,
                       dio_in: snap_in.dio_in, rio_out: rio_q,
                       op_num: snap_in.op_num, op_kind: snap_in.op_kind,
                       fb_pos: snap_in.fb_pos,
                       t_boot: t_boot, t_main: t_main,
                       t_move: op_start_in ? 32'h0000_0000 : t_move};
    end
  end

  // Index 0 is the oldest stored record
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) rd_rec_out <= '0;
    else            rd_rec_out <= mem_q[AW'(((AW+1)'(old_idx) + (AW+1)'(rd_idx_in)) % DEPTH)];
  end
  assign count_out = cnt_q;

  property p_travel;
    @(posedge clock_in) disable iff (!arst_n_in)
      (op_start_in && op_in.positioning && tr_bad) |=>
        opdata_alarm_out && opdata_sub_out == 8'h01;
  endproperty
  a_travel: assert property (p_travel) else $error("travel alarm missing");

  property p_wrap;
    @(posedge clock_in) disable iff (!arst_n_in)
      (op_start_in && op_in.uses_wrap && !wrap_en_in && !(op_in.positioning && tr_bad))
        |=> opdata_sub_out == 8'h02;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap alarm missing");

  property p_speed0;
    @(posedge clock_in) disable iff (!arst_n_in)
      (op_start_in && op_in.positioning && !tr_bad && !(op_in.uses_wrap && !wrap_en_in) &&
       op_in.travel != 33'h0_0000_0000 && op_in.op_speed == 32'h0000_0000)
        |=> opdata_alarm_out && opdata_sub_out == 8'h03;
  endproperty
  a_speed0: assert property (p_speed0) else $error("zero speed alarm missing");

  property p_nofollow;
    @(posedge clock_in) disable iff (!arst_n_in)
      !follow_sensor_in |-> sub_sel < 8'h04;
  endproperty
  a_nofollow: assert property (p_nofollow) else $error("limit check without follow");

  property p_mismatch;
    @(posedge clock_in) disable iff (!arst_n_in)
      (motor_valid_in && motor_in.motor_dc != drv_dc_in) |=> combo_alarm_out;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("supply mismatch missed");

  property p_oldfw;
    @(posedge clock_in) disable iff (!arst_n_in)
      (motor_valid_in && motor_in.actuator && fw_rev_in < 16'h0202) |=> combo_alarm_out;
  endproperty
  a_oldfw: assert property (p_oldfw) else $error("old firmware actuator missed");

  property p_record;
    @(posedge clock_in) disable iff (!arst_n_in)
      (ev && cnt_q < (AW+1)'(DEPTH)) |=> cnt_q == $past(cnt_q) + (AW+1)'(1);
  endproperty
  a_record: assert property (p_record) else $error("record not counted");

  property p_code;
    @(posedge clock_in) disable iff (!arst_n_in)
      (op_err && !combo_rise) |=> mem_q[$past(wp_q)].code == 8'h70;
  endproperty
  a_code: assert property (p_code) else $error("record code wrong");
endmodule : ahc_alarm_history

// ==== design/ahc_cfg.svh ====
`ifndef AHC_CFG_SVH
`define AHC_CFG_SVH
`define AHC_ALM_OPDATA     8'h70
`define AHC_ALM_COMBO      8'h45
`define AHC_SUB_NONE       8'h00
`define AHC_SUB_TRAVEL     8'h01
`define AHC_SUB_WRAP       8'h02
`define AHC_SUB_SPEED0     8'h03
`define AHC_SUB_OPSPD      8'h04
`define AHC_SUB_STSPD      8'h05
`define AHC_SUB_PUSHSPD    8'h06
`define AHC_SUB_PUSHCUR    8'h07
`define AHC_SUB_HOME       8'h08
`define AHC_TRAVEL_MAX     33'sh0_7FFF_FFFF
`define AHC_FW_ACTUATOR    16'h0202
`define AHC_FW_HV_CHECK    16'h0310
`define AHC_FW_FRAC_LEAD   16'h0410
`define AHC_TICK_NS        1000
`define AHC_CLK_NS         10
`define AHC_TICK_CYC       (`AHC_TICK_NS / `AHC_CLK_NS)
`endif

// ==== design/ahc_pkg.sv ====
package ahc_pkg;
  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  sub;
    logic [15:0] drv_temp;
    logic [15:0] mot_temp;
    logic [15:0] inv_volt;
    logic [15:0] dio_in;
    logic [15:0] rio_out;
    logic [7:0]  op_num;
    logic [7:0]  op_kind;
    logic [31:0] fb_pos;
    logic [31:0] t_boot;
    logic [31:0] t_move;
    logic [31:0] t_main;
  } ahc_rec_s;

  typedef struct packed {
    logic [15:0] drv_temp;
    logic [15:0] mot_temp;
    logic [15:0] inv_volt;
    logic [15:0] dio_in;
    logic [15:0] rio_out;
    logic [7:0]  op_num;
    logic [7:0]  op_kind;
    logic [31:0] fb_pos;
  } ahc_snap_s;

  typedef struct packed {
    logic        positioning;
    logic        uses_wrap;
    logic        push;
    logic        home;
    logic [32:0] travel;
    logic [31:0] op_speed;
    logic [31:0] st_speed;
    logic [31:0] push_speed;
    logic [15:0] push_cur;
    logic [31:0] home_speed;
  } ahc_op_s;

  typedef struct packed {
    logic [31:0] max_op_speed;
    logic [31:0] max_st_speed;
    logic [31:0] max_push_speed;
    logic [15:0] max_push_cur;
    logic [31:0] max_home_speed;
  } ahc_lim_s;

  typedef struct packed {
    logic        motor_dc;
    logic        actuator;
    logic        small_frame;
    logic        frac_lead;
  } ahc_motor_s;
endpackage : ahc_pkg

// ==== design/ahc_timers.sv ====
`timescale 1ns/1ps
`include "ahc_cfg.svh"
module ahc_timers
  import ahc_pkg::*;
#(
  parameter int TICK_CYC = `AHC_TICK_CYC
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        arst_n_in,
  // Power and motion status
  input  wire logic        ctrl_pwr_present_in,
  input  wire logic        ctrl_pwr_on_in,
  input  wire logic        main_pwr_on_in,
  input  wire logic        motion_start_in,
  // Elapsed times in ticks
  output logic [31:0]      t_boot_out,
  output logic [31:0]      t_move_out,
  output logic [31:0]      t_main_out
);
  logic [15:0] pre_q;
  logic        tick;
  logic        boot_src;

  assign tick     = (pre_q == 16'(TICK_CYC - 1));
  // Without a separate control supply the boot time counts from main power
  assign boot_src = ctrl_pwr_present_in ? ctrl_pwr_on_in : main_pwr_on_in;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      t_boot_out <= 32'h0000_0000;
      t_move_out <= 32'h0000_0000;
      t_main_out <= 32'h0000_0000;
    end else begin
      if (!boot_src) t_boot_out <= 32'h0000_0000;
      else if (tick) t_boot_out <= t_boot_out + 32'h0000_0001;
      if (motion_start_in) t_move_out <= 32'h0000_0000;
      else if (tick) t_move_out <= t_move_out + 32'h0000_0001;
      if (!main_pwr_on_in) t_main_out <= 32'h0000_0000;
      else if (tick) t_main_out <= t_main_out + 32'h0000_0001;
    end
  end

  property p_boot_src;
    @(posedge clock_in) disable iff (!arst_n_in)
      !boot_src |=> (t_boot_out == 32'h0000_0000);
  endproperty
  a_boot_src: assert property (p_boot_src) else $error("boot time not held at zero");
endmodule : ahc_timers

// ==== verification/ahc_motor_model.sv ====
`timescale 1ns/1ps
module ahc_motor_model
  import ahc_pkg::*;
(
  // Motor type select
  input  wire logic [3:0] kind_in,
  // Motor identity and sensor maxima
  output logic            valid_out,
  output ahc_motor_s      motor_out,
  output ahc_lim_s        lim_out
);
  // Sensor maxima stay fixed, as stored values in the sensor do
  assign valid_out = 1'b1;
  assign motor_out = ahc_motor_s'(kind_in);
  assign lim_out   = '{32'h0000_0200, 32'h0000_0100, 32'h0000_0080, 16'h0040,
                       32'h0000_0080};
endmodule : ahc_motor_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import ahc_pkg::*;
;
  logic        clock_in, arst_n_in, drv_dc, s48, follow, op_start, ext_alarm;
  logic        ctrl_present, ctrl_on, main_on, motor_valid, combo, opd, wrap_en;
  logic [15:0] fw_rev;
  logic [7:0]  ext_code, sub;
  logic [3:0]  kind;
  logic [1:0]  rd_idx;
  logic [2:0]  count;
  ahc_op_s     op;
  ahc_snap_s   snap;
  ahc_motor_s  motor;
  ahc_lim_s    lim;
  ahc_rec_s    rec;
  int          miscompares, check_count;
  localparam logic [23:0] CMB [9] = '{24'h48_0410, 24'hc0_0410, 24'hcc_0201,
    24'h4c_0202, 24'hea_0310, 24'hcd_0409, 24'h4d_0410, 24'h88_0410, 24'h00_0410};

  ahc_motor_model i_motor (.kind_in(kind), .valid_out(motor_valid), .motor_out(motor),
                           .lim_out(lim));
  ahc_alarm_history #(.DEPTH(4), .TICK_CYC(2)) i_dut (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .drv_dc_in(drv_dc), .fw_rev_in(fw_rev),
    .supply_48v_in(s48), .wrap_en_in(wrap_en), .follow_sensor_in(follow),
    .motor_valid_in(motor_valid), .motor_in(motor), .lim_in(lim),
    .op_start_in(op_start), .op_in(op), .ext_alarm_in(ext_alarm),
    .ext_code_in(ext_code), .ext_sub_in(8'h11), .snap_in(snap),
    .ctrl_pwr_present_in(ctrl_present), .ctrl_pwr_on_in(ctrl_on),
    .main_pwr_on_in(main_on), .combo_alarm_out(combo), .opdata_alarm_out(opd),
    .opdata_sub_out(sub), .rd_idx_in(rd_idx), .rd_rec_out(rec), .count_out(count));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task tick;
    @(posedge clock_in);
    #1;
  endtask : tick

  task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task summarize;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  // Case 0 is clean, 9 is one past the negative travel bound, 10 the largest legal travel
  task op_go(input int k);
    op = '{positioning: 1'b1, travel: 33'h0_0000_0064, op_speed: 32'h0000_0100,
           st_speed: 32'h0000_0080, push_speed: 32'h0000_0040, push_cur: 16'h0020,
           home_speed: 32'h0000_0040, default: '0};
    case (k)
      1: op.travel = 33'h0_8000_0000;
      2: op.uses_wrap = 1'b1;
      3: op.op_speed = '0;
      4: op.op_speed = 32'h0000_0201;
      5: op.st_speed = 32'h0000_0101;
      6: {op.push, op.push_speed} = {1'b1, 32'h0000_0081};
      7: {op.push, op.push_cur} = {1'b1, 16'h0041};
      8: {op.home, op.home_speed} = {1'b1, 32'h0000_0081};
      9: op.travel = 33'h1_8000_0000;
      10: op.travel = 33'h0_7fff_ffff;
      default: ;
    endcase
    op_start = 1'b1;
    tick;
    op_start = 1'b0;
  endtask : op_go

  task t_history;
    repeat (20) tick;
    op_go(1);
    chk("count", 3'd1, count);
    rd_idx = 2'd0;
    tick;
    chk("rec_code_sub", 16'h7001, {rec.code, rec.sub});
    chk("rec_analog", {snap.drv_temp, snap.mot_temp, snap.inv_volt},
        {rec.drv_temp, rec.mot_temp, rec.inv_volt});
    chk("rec_io", {snap.dio_in, snap.rio_out}, {rec.dio_in, rec.rio_out});
    chk("rec_op", {snap.op_num, snap.op_kind, snap.fb_pos},
        {rec.op_num, rec.op_kind, rec.fb_pos});
    // Ten two-cycle ticks pass between reset release and the event
    chk("t_boot", 32'h0000_000a, rec.t_boot);
    chk("t_main", 32'h0000_000a, rec.t_main);
    chk("t_move", 32'h0000_0000, rec.t_move);
  endtask : t_history

  task t_opdata;
    logic [7:0] e;
    for (int k = 0; k <= 10; k++) begin
      e = (k == 9) ? 8'h01 : (k == 10) ? 8'h00 : 8'(k);
      op_go(k);
      chk("opdata_alarm", e != 0, opd);
      if (e != 0)
        chk("opdata_sub", e, sub);
      tick;
    end
    // Enabled wrap and driver-held limits must both let the start through
    wrap_en = 1'b1;
    follow  = 1'b0;
    op_go(2);
    chk("wrap_enabled", 1'b0, opd);
    tick;
    op_go(4);
    chk("no_follow", 1'b0, opd);
    {wrap_en, follow} = 2'b01;
  endtask : t_opdata

  task t_combo;
    for (int i = 0; i < 9; i++) begin
      {drv_dc, s48} = CMB[i][22:21];
      kind = CMB[i][19:16];
      fw_rev = CMB[i][15:0];
      tick;
      tick;
      chk("combo_alarm", CMB[i][23], combo);
      if (i == 1) begin
        rd_idx = 2'd3;
        tick;
        chk("rec_code", 16'h4500, {rec.code, rec.sub});
      end
    end
  endtask : t_combo

  task t_overwrite;
    ext_alarm = 1'b1;
    for (int i = 0; i < 6; i++) begin
      ext_code = 8'ha0 + 8'(i);
      tick;
    end
    ext_alarm = 1'b0;
    chk("count", 3'd4, count);
    for (int i = 0; i < 4; i++) begin
      rd_idx = 2'(i);
      tick;
      chk("rec_code", 8'ha2 + 8'(i), rec.code);
    end
  endtask : t_overwrite

  initial begin
    repeat (5000) @(posedge clock_in);
    miscompares++;
    summarize;
  end

  initial begin
    {arst_n_in, s48, wrap_en, op_start, ext_alarm, ctrl_present, ctrl_on} = '0;
    {drv_dc, main_on, follow} = 3'b111;
    fw_rev = 16'h0410;
    kind = 4'h8;
    ext_code = 8'h00;
    rd_idx = 2'd0;
    op = '0;
    snap = '{16'h0123, 16'h0456, 16'h0789, 16'h0abc, 16'h0def, 8'h05, 8'h03, 32'h0001_2345};
    repeat (4) @(posedge clock_in);
    #1;
    arst_n_in = 1'b1;
    t_history;
    t_opdata;
    t_combo;
    t_overwrite;
    summarize;
  end
endmodule : testbench
